// [common/ipr_cfg.svh]
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH
// Function
// [RULE1] Scale with ratios reaching up to a fourfold enlargement of the input.
// [RULE2] Accept interleaved 4:2:2 luma/chroma or one separated colour plane.
// [RULE3] In the reducing range filter with four phases of seven taps; code uses seven taps only for steps above 512 (ratios below one half).
// [RULE4] In the upper range, up to fourfold, filter with eight phases of four taps.
// [RULE5] Tap structure is chosen by hardware from the step alone, never by software.
// [RULE6] Horizontal stage first; its lines go to a line buffer feeding the vertical stage.
// [RULE7] Line buffer holds four lines for four taps, seven lines for seven taps.
// [RULE8] Requester keeps output width within 640 (seven taps) or 1280 (four taps).
// [RULE9] Ratio is 256 over the step, the step limited to 64 through 1024.
// [RULE10] Input from capture path or memory; scaled output always goes to memory.
// [RULE11] Each output pixel advances a position by the step; integer picks, fraction phases.
// [RULE12] Stall horizontal when buffer full, vertical until enough lines are present.
`define IPR_FRAC_BITS 8
`define IPR_STEP_MIN 11'h040
`define IPR_STEP_MAX 11'h400
`define IPR_STEP_7TAP 11'h200
`define IPR_TAPS7 3'h7
`define IPR_TAPS4 3'h4
`define IPR_MAX_W 1280
`define IPR_LB_LINES 7
`define IPR_COEF_SHIFT 6
`endif

// [common/ipr_pkg.sv]
package ipr_pkg;
	typedef struct packed {
		logic [7:0] chroma;
		logic [7:0] luma;
	} ipr_pix_s;
	typedef struct packed {
		logic [10:0] step;
		logic [10:0] inWidth;
		logic [10:0] outWidth;
		logic [10:0] outHeight;
		logic planar;
		logic srcMem;
	} ipr_cfg_s;
	typedef enum logic [1:0] {H_IDLE, H_RUN, H_TAIL, H_WAIT} ipr_hst_e;
endpackage : ipr_pkg

// [rtl/ipr_core.sv]
`include "ipr_cfg.svh"
module ipr_core #(
	parameter int MAX_W = `IPR_MAX_W,
	parameter int LINES = `IPR_LB_LINES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Frame control
	input wire logic start,
	input wire ipr_pkg::ipr_cfg_s cfg,
	output logic busy,
	output logic frameDone,
	// Capture path input
	input wire logic capValid,
	input wire ipr_pkg::ipr_pix_s capData,
	output logic capReady,
	// Memory read input
	input wire logic memValid,
	input wire ipr_pkg::ipr_pix_s memData,
	output logic memReady,
	// Scaled output towards memory
	output logic outValid,
	output ipr_pkg::ipr_pix_s outData,
	output logic outLast,
	input wire logic outReady
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [10:0] clampStep(input logic [10:0] s);
		if (s < `IPR_STEP_MIN) return `IPR_STEP_MIN; // see [RULE9]
		if (s > `IPR_STEP_MAX) return `IPR_STEP_MAX; // see [RULE1]
		return s;
	endfunction : clampStep

	function automatic logic [2:0] slotOf(input logic [2:0] b, input logic [3:0] k);
		logic [3:0] s;
		s = {1'b0, b} + k;
		return (s >= 4'(LINES)) ? 3'(s - 4'(LINES)) : s[2:0];
	endfunction : slotOf

	// Weights always sum to 64 so the result never overflows eight bits.
	function automatic logic [6:0] coefW(input logic s7, input logic [2:0] ph, input int k);
		if (s7) begin
			case (k)
				0: return 7'h08 - 7'({ph, 1'b0});
				3: return 7'h0c;
				6: return 7'({ph, 1'b0});
				default: return 7'h0b;
			endcase
		end
		case (k)
			1: return 7'h40 - 7'({ph, 3'b000});
			2: return 7'({ph, 3'b000});
			default: return 7'h00;
		endcase
	endfunction : coefW

	function automatic ipr_pkg::ipr_pix_s filt(input ipr_pkg::ipr_pix_s [6:0] t, input logic s7,
			input logic [2:0] ph, input logic planar);
		logic [14:0] accL;
		logic [14:0] accC;
		ipr_pkg::ipr_pix_s r;
		accL = '0;
		accC = '0;
		for (int k = 0; k < 7; k++) begin
			accL = accL + {8'h00, coefW(s7, ph, k)} * {7'h00, t[k].luma};
			accC = accC + {8'h00, coefW(s7, ph, k)} * {7'h00, t[k].chroma};
		end
		r.luma = accL[`IPR_COEF_SHIFT +: 8];
		r.chroma = planar ? 8'h00 : accC[`IPR_COEF_SHIFT +: 8]; // see [RULE2]
		return r;
	endfunction : filt

	function automatic logic wantIn(input ipr_pkg::ipr_hst_e st, input logic [10:0] col,
			input logic [10:0] cnt, input logic [21:0] p, input ipr_pkg::ipr_cfg_s c,
			input logic [2:0] t);
		if (st == ipr_pkg::H_TAIL) return cnt < c.inWidth;
		return st == ipr_pkg::H_RUN && col != c.outWidth && cnt < c.inWidth
			&& {3'h0, cnt} < p[21:`IPR_FRAC_BITS] + {11'h000, t}; // see [RULE11]
	endfunction : wantIn

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ipr_pkg::ipr_cfg_s cfgR, next_cfgR;
	ipr_pkg::ipr_hst_e hst, next_hst;
	ipr_pkg::ipr_pix_s [6:0] hwin, next_hwin;
	ipr_pkg::ipr_pix_s [6:0] hTap;
	ipr_pkg::ipr_pix_s [6:0] vTap;
	ipr_pkg::ipr_pix_s lbuf [LINES][MAX_W];
	ipr_pkg::ipr_pix_s inData, hPix, next_outData;
	logic [21:0] pos, next_pos, vpos, next_vpos, vposAdv;
	logic [10:0] inCount, next_inCount, hCol, next_hCol, vCol, next_vCol, vRow, next_vRow;
	logic [2:0] head, next_head, taps, hPh, vPh, vdrop, wrSlot;
	logic [3:0] held, next_held;
	logic next_busy, next_frameDone, next_capReady, next_memReady, next_outValid, next_outLast;
	logic seven, inAcc, lbWe, hProduce, hinc, vFire;

	// Step alone picks the tap structure; there is no software override.
	assign seven = cfgR.step > `IPR_STEP_7TAP; // see [RULE5]
	assign taps = seven ? `IPR_TAPS7 : `IPR_TAPS4; // see [RULE7]
	assign hPh = seven ? {1'b0, pos[7:6]} : pos[7:5]; // see [RULE3] see [RULE4]
	assign vPh = seven ? {1'b0, vpos[7:6]} : vpos[7:5];
	assign wrSlot = slotOf(head, held);
	assign hPix = filt(hTap, seven, hPh, cfgR.planar);
	assign inData = cfgR.srcMem ? memData : capData; // see [RULE10]
	assign inAcc = cfgR.srcMem ? (memValid && memReady) : (capValid && capReady);
	assign vposAdv = vpos + {11'h000, cfgR.step};

	// Oldest pixel or line feeds tap zero.
	for (genvar gk = 0; gk < 7; gk++) begin : g_tap
		assign hTap[gk] = (3'(gk) < taps) ? hwin[3'(taps - 3'(gk) - 3'h1)] : '0;
		// Taps above the active count read as zero, since their slots may never have been written.
		assign vTap[gk] = (3'(gk) < taps) ? lbuf[slotOf(head, 4'(gk))][vCol] : '0; // see [RULE7]
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_cfgR = cfgR;
		next_hst = hst;
		next_hwin = hwin;
		next_pos = pos;
		next_inCount = inCount;
		next_hCol = hCol;
		next_vpos = vpos;
		next_vCol = vCol;
		next_vRow = vRow;
		next_head = head;
		next_busy = busy;
		next_frameDone = 1'b0;
		next_outValid = outValid;
		next_outData = outData;
		next_outLast = outLast;
		lbWe = 1'b0;
		hProduce = 1'b0;
		hinc = 1'b0;
		vFire = 1'b0;
		vdrop = 3'h0;
		if (!busy) begin
			if (start) begin
				next_cfgR = cfg;
				next_cfgR.step = clampStep(cfg.step); // see [RULE9]
				next_busy = 1'b1;
				next_hst = ipr_pkg::H_RUN;
				next_pos = '0;
				next_inCount = '0;
				next_hCol = '0;
				next_vpos = '0;
				next_vCol = '0;
				next_vRow = '0;
				next_head = '0;
			end
		end else begin
			case (hst)
				ipr_pkg::H_RUN: begin
					if (hCol == cfgR.outWidth) begin
						next_hst = ipr_pkg::H_TAIL;
					end else if (wantIn(hst, hCol, inCount, pos, cfgR, taps)) begin
						if (inAcc) begin
							next_hwin = {hwin[5:0], inData};
							next_inCount = inCount + 11'h001;
						end
					end else begin
						// Width bound is kept by the requester; column indexes the buffer.
						hProduce = 1'b1;
						lbWe = 1'b1; // see [RULE6] see [RULE8]
						next_pos = pos + {11'h000, cfgR.step}; // see [RULE11]
						next_hCol = hCol + 11'h001;
					end
				end
				ipr_pkg::H_TAIL: begin
					// Unused input pixels of the line are drained and dropped.
					if (inCount >= cfgR.inWidth) begin
						hinc = 1'b1;
						next_hst = ipr_pkg::H_WAIT;
					end else if (inAcc) begin
						next_inCount = inCount + 11'h001;
					end
				end
				ipr_pkg::H_WAIT: begin
					next_pos = '0;
					next_inCount = '0;
					next_hCol = '0;
					if (held < {1'b0, taps}) next_hst = ipr_pkg::H_RUN; // see [RULE12]
				end
				default: begin
					next_hst = ipr_pkg::H_IDLE;
				end
			endcase
		end
		if (!outValid || outReady) begin
			next_outValid = 1'b0;
			next_outLast = 1'b0;
			if (busy && held >= {1'b0, taps} && vRow < cfgR.outHeight) begin
				vFire = 1'b1; // see [RULE12]
				next_outData = filt(vTap, seven, vPh, cfgR.planar);
				next_outValid = 1'b1; // see [RULE10]
				next_outLast = vCol == cfgR.outWidth - 11'h001;
				next_vCol = vCol + 11'h001;
				if (vCol == cfgR.outWidth - 11'h001) begin
					next_vCol = '0;
					next_vRow = vRow + 11'h001;
					next_vpos = vposAdv;
					vdrop = 3'(vposAdv[21:`IPR_FRAC_BITS] - vpos[21:`IPR_FRAC_BITS]);
					next_head = slotOf(head, {1'b0, vdrop});
					if (vRow + 11'h001 == cfgR.outHeight) begin
						next_busy = 1'b0;
						next_frameDone = 1'b1;
						next_hst = ipr_pkg::H_IDLE;
					end
				end
			end
		end
		// Slot being written stays fixed: head and held move by the same drop.
		next_held = (next_busy && busy) ? held + {3'h0, hinc} - {1'b0, vdrop} : 4'h0;
		next_capReady = wantIn(next_hst, next_hCol, next_inCount, next_pos, next_cfgR, 
			(next_cfgR.step > `IPR_STEP_7TAP) ? `IPR_TAPS7 : `IPR_TAPS4) && next_busy
			&& !next_cfgR.srcMem;
		next_memReady = wantIn(next_hst, next_hCol, next_inCount, next_pos, next_cfgR,
			(next_cfgR.step > `IPR_STEP_7TAP) ? `IPR_TAPS7 : `IPR_TAPS4) && next_busy
			&& next_cfgR.srcMem;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfgR <= '0;
			hst <= ipr_pkg::H_IDLE;
			hwin <= '0;
			pos <= '0;
			inCount <= '0;
			hCol <= '0;
			vpos <= '0;
			vCol <= '0;
			vRow <= '0;
			head <= '0;
			held <= '0;
			busy <= 1'b0;
			frameDone <= 1'b0;
			capReady <= 1'b0;
			memReady <= 1'b0;
			outValid <= 1'b0;
			outData <= '0;
			outLast <= 1'b0;
		end else begin
			cfgR <= next_cfgR;
			hst <= next_hst;
			hwin <= next_hwin;
			pos <= next_pos;
			inCount <= next_inCount;
			hCol <= next_hCol;
			vpos <= next_vpos;
			vCol <= next_vCol;
			vRow <= next_vRow;
			head <= next_head;
			held <= next_held;
			busy <= next_busy;
			frameDone <= next_frameDone;
			capReady <= next_capReady;
			memReady <= next_memReady;
			outValid <= next_outValid;
			outData <= next_outData;
			outLast <= next_outLast;
		end
	end

	// Line buffer storage has no reset; reads only follow completed writes.
	always_ff @(posedge clk) begin
		if (lbWe) lbuf[wrSlot][hCol] <= hPix; // see [RULE6]
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_step_range: assert property (busy |-> cfgR.step >= `IPR_STEP_MIN
		&& cfgR.step <= `IPR_STEP_MAX) else $error("step outside legal range"); // see [RULE9]
	a_four_x_limit: assert property ($rose(busy) |-> cfgR.step >= `IPR_STEP_MIN)
		else $error("enlargement beyond fourfold"); // see [RULE1]
	a_seven_phases: assert property ((busy && cfgR.step > `IPR_STEP_7TAP) |-> taps == 3'h7
		&& hPh < 3'h4) else $error("seven-tap geometry wrong"); // see [RULE3]
	a_four_taps: assert property ((busy && cfgR.step <= `IPR_STEP_7TAP) |-> taps == 3'h4)
		else $error("four-tap geometry wrong"); // see [RULE4] see [RULE5]
	a_buffer_limit: assert property (held <= {1'b0, taps})
		else $error("line buffer over capacity"); // see [RULE7]
	a_no_early: assert property (vFire |-> held >= {1'b0, taps})
		else $error("vertical read before lines present"); // see [RULE12]
	a_pos_advance: assert property (hProduce |=> pos == $past(pos) + {11'h000, cfgR.step})
		else $error("position did not advance by step"); // see [RULE11]
	a_out_hold: assert property ((outValid && !outReady) |=> outValid && $stable(outData))
		else $error("output dropped while stalled"); // see [RULE10]
	a_src_route: assert property (!(capReady && memReady))
		else $error("both sources enabled"); // see [RULE10]
	a_planar_chroma: assert property ((outValid && cfgR.planar) |-> outData.chroma == 8'h00)
		else $error("planar chroma lane not zero"); // see [RULE2]
	a_write_stage: assert property (lbWe |-> hst == ipr_pkg::H_RUN && held < {1'b0, taps})
		else $error("line write outside horizontal run"); // see [RULE6]

	c_seven_frame: cover property (frameDone && seven);
	c_four_frame: cover property (frameDone && !seven);
	c_out_stall: cover property (outValid && !outReady ##1 outValid && outReady);
	c_horiz_wait: cover property (hst == ipr_pkg::H_WAIT ##1 hst == ipr_pkg::H_WAIT);
endmodule : ipr_core

// [tb/ipr_far_side.sv]
module ipr_far_side (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Scenario control
	input wire logic srcMem,
	input wire logic slow,
	input wire ipr_pkg::ipr_pix_s fill,
	// Capture path and memory sources
	output logic capValid,
	output ipr_pkg::ipr_pix_s capData,
	input wire logic capReady,
	output logic memValid,
	output ipr_pkg::ipr_pix_s memData,
	input wire logic memReady,
	// Memory sink
	output logic outReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] tick = 2'h0;
	logic took = 1'b0;
	initial begin
		capValid = 1'b0;
		memValid = 1'b0;
		outReady = 1'b0;
	end
	always @(posedge clk) begin
		took <= (capValid && capReady) || (memValid && memReady);
	end
	// A beat stays offered until taken; a slow source only pauses between beats.
	always @(negedge clk) begin
		tick <= tick + 2'h1;
		outReady <= rstn && (!slow || tick != 2'h0);
		if (!rstn) begin
			capValid <= 1'b0;
			memValid <= 1'b0;
		end else if (took || !(srcMem ? memValid : capValid)) begin
			capValid <= !srcMem && (!slow || tick[0]);
			memValid <= srcMem && (!slow || tick[0]);
		end
	end
	// Idle lines show the inverse so that a stale beat can never pass as fresh data.
	assign capData = capValid ? fill : ipr_pkg::ipr_pix_s'(~fill);
	assign memData = memValid ? fill : ipr_pkg::ipr_pix_s'(~fill);
endmodule : ipr_far_side

// [tb/tb_image_polyphase_resizer.sv]
module tb_image_polyphase_resizer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic slow = 1'b0;
	ipr_pkg::ipr_cfg_s cfg = '0;
	ipr_pkg::ipr_pix_s fill = 16'h5a3c;
	ipr_pkg::ipr_pix_s capData, memData, outData;
	logic busy, frameDone, capValid, capReady, memValid, memReady, outValid, outLast, outReady;
	int n_errors = 0;
	int total_checks = 0;
	int nPix = 0;
	int nLast = 0;
	int nBad = 0;
	int nIn = 0;
	always #10 clk = ~clk;
	ipr_core dut_u (.clk(clk), .rstn(rstn), .start(start), .cfg(cfg), .busy(busy),
		.frameDone(frameDone), .capValid(capValid), .capData(capData), .capReady(capReady),
		.memValid(memValid), .memData(memData), .memReady(memReady), .outValid(outValid),
		.outData(outData), .outLast(outLast), .outReady(outReady));
	ipr_far_side far_u (.clk(clk), .rstn(rstn), .srcMem(cfg.srcMem), .slow(slow), .fill(fill),
		.capValid(capValid), .capData(capData), .capReady(capReady), .memValid(memValid),
		.memData(memData), .memReady(memReady), .outReady(outReady));
	// ----------------------------------------
	// Output monitor
	// ----------------------------------------
	// A flat picture must come out unchanged, since every tap set has unity gain.
	always @(posedge clk) begin
		if (rstn && outValid && outReady) begin
			if (outData !== {cfg.planar ? 8'h00 : fill.chroma, fill.luma}) nBad++;
			if (outLast !== (nPix % cfg.outWidth == cfg.outWidth - 1)) nBad++;
			nPix++;
			nLast += outLast;
		end
		if (rstn && (cfg.srcMem ? capReady : memReady) !== 1'b0) nBad++;
		if (rstn && ((capValid && capReady) || (memValid && memReady))) nIn++;
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic run_frame(input logic [10:0] step, input logic [10:0] inW,
		input logic [10:0] outW, input logic [10:0] outH, input logic pl, input logic mem,
		input logic slw, input logic poke);
		int n;
		@(negedge clk);
		cfg = '{step, inW, outW, outH, pl, mem};
		slow = slw;
		nPix = 0;
		nLast = 0;
		nBad = 0;
		nIn = 0;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		check("busy after start", 1, busy);
		n = 0;
		while (frameDone !== 1'b1 && n < 40000) begin
			@(negedge clk);
			n++;
			start = poke && n == 20;
		end
		start = 1'b0;
		check("frame done", 1, frameDone);
		check("busy at frame end", 0, busy);
		@(negedge clk);
		check("done pulse", 0, frameDone);
		n = 0;
		while (outValid === 1'b1 && n < 16) begin
			@(negedge clk);
			n++;
		end
		check("pixels", outW * outH, nPix);
		check("row ends", outH, nLast);
		check("bad beats", 0, nBad);
	endtask : run_frame
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_four_tap;
		run_frame(11'h100, 11'h020, 11'h020, 11'h003, 1'b0, 1'b0, 1'b0, 1'b0);
		// Rows 0..2 at unity step need four lines, then one more per later row.
		check("four-tap input beats", 6 * 32, nIn);
	endtask : t_four_tap
	task automatic t_mode_edge;
		run_frame(11'h200, 11'h028, 11'h014, 11'h003, 1'b0, 1'b0, 1'b0, 1'b0);
		run_frame(11'h201, 11'h028, 11'h014, 11'h003, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask : t_mode_edge
	task automatic t_enlarge;
		run_frame(11'h040, 11'h00a, 11'h01c, 11'h005, 1'b0, 1'b1, 1'b0, 1'b0);
	endtask : t_enlarge
	task automatic t_clamp;
		run_frame(11'h020, 11'h00a, 11'h01c, 11'h003, 1'b0, 1'b0, 1'b0, 1'b0);
		run_frame(11'h7ff, 11'h040, 11'h008, 11'h002, 1'b0, 1'b1, 1'b0, 1'b0);
		// A step held at 1024 moves the second row four lines on: eleven lines in all.
		check("clamped input beats", 11 * 64, nIn);
	endtask : t_clamp
	task automatic t_planar;
		run_frame(11'h0c0, 11'h018, 11'h020, 11'h004, 1'b1, 1'b1, 1'b0, 1'b0);
	endtask : t_planar
	task automatic t_stall;
		run_frame(11'h12c, 11'h030, 11'h028, 11'h006, 1'b0, 1'b1, 1'b1, 1'b1);
		run_frame(11'h0a0, 11'h020, 11'h030, 11'h006, 1'b0, 1'b0, 1'b1, 1'b0);
	endtask : t_stall
	task automatic t_widths;
		run_frame(11'h201, 11'h500, 11'h280, 11'h001, 1'b0, 1'b1, 1'b0, 1'b0);
		run_frame(11'h100, 11'h500, 11'h500, 11'h001, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask : t_widths
	initial begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		check("idle busy", 0, busy);
		check("idle out valid", 0, outValid);
		check("idle cap ready", 0, capReady);
		t_four_tap();
		t_mode_edge();
		t_enlarge();
		t_clamp();
		t_planar();
		t_stall();
		t_widths();
		results();
	end
	// The whole sequence needs under half of this span.
	initial begin
		#1_500_000;
		n_errors++;
		$display("[FAIL] watchdog expected finish seen hang");
		results();
	end
endmodule : tb_image_polyphase_resizer
